// *** pmw_consts.svh ***
// Constants for the power mode and wake control link
`ifndef PMW_CONSTS_SVH
`define PMW_CONSTS_SVH
`define OFS_GLOBAL_RESET_WAKE 8'h26
`define OFS_INTERRUPT_ENABLE 8'h90
`define OFS_INTERRUPT_STATUS 8'h92
`define OFS_SLEEP_WAKE_TIME 8'h9a
`define OFS_POWER_EVENT_CONTROL 8'hd4
`define OFS_PORT_LINK_CONTROL 8'hf4
`define MODE_NORMAL 2'h0
`define MODE_ENERGY 2'h1
`define MODE_SOFT_DOWN 2'h2
`define MODE_SAVING 2'h3
`define PEC_WAKE_TO_NORMAL 6
`define PEC_AUTO_WAKE 7
`define PEC_PME_EN_LSB 8
`define IRQ_EV_LSB 2
`define PLC_SAVE_EN 10
`define SWT_SLEEP_LSB 0
`define SWT_WAKE_LSB 8
`define RST_GLOBAL_RESET_WAKE 16'h0000
`define RST_INTERRUPT_ENABLE 16'h0000
`define RST_SLEEP_WAKE_TIME 16'h0808
`define RST_POWER_EVENT_CONTROL 16'h0000
`define RST_PORT_LINK_CONTROL 16'h0000
`define CLK_MHZ 25
`define TICK_US 1000
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define HOF_ADDR 8'h00
`define HOF_WDATA 8'h04
`define HOF_CMD 8'h08
`define HOF_STATUS 8'h0c
`define HOF_PIN 8'h10
`endif

// *** pmw_if.sv ***
// Link between host processor end and power mode controller end
`timescale 1ns/1ps
`default_nettype none
interface pmw_if;
	logic cs;
	logic wr;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic ack;
	logic host_irq_n;
	logic power_event_out;
	logic chip_power_down_n;
	modport dev (input cs, wr, addr, wdata, chip_power_down_n,
		output rdata, ack, host_irq_n, power_event_out);
	modport host (output cs, wr, addr, wdata, chip_power_down_n,
		input rdata, ack, host_irq_n, power_event_out);
endinterface
`default_nettype wire

// *** pmw_pkg.sv ***
// Types of the power mode link: power states of the device end, sequencer states of the host end
package pmw_pkg;
	typedef enum logic [2:0] {
		PS_NORMAL, PS_ED_AWAKE, PS_ED_LOW, PS_SOFT_DOWN, PS_SAVE_WAIT, PS_SAVE
	} power_state_t;
	typedef enum logic [1:0] {HS_IDLE, HS_REQ, HS_GAP} host_state_t;
endpackage

// *** power_host_end.sv ***
// Host processor end: APB command registers driving the device bus
`timescale 1ns/1ps
`default_nettype none
`include "pmw_consts.svh"
module power_host_end
	import pmw_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_ce,
	pmw_if.host bus,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr
);
	// ****************************************
	// APB decode
	// ****************************************
	logic [7:0] addr_reg;
	logic [15:0] wdata_reg;
	logic [15:0] last_rd_reg;
	logic pd_n_reg;
	logic cs_reg;
	logic wr_reg;
	host_state_t hs_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic busy;
	assign busy = hs_reg != HS_IDLE;
	logic access;
	assign access = i_psel && i_penable;
	logic done;
	assign done = access && pready_reg;
	logic mapped;
	assign mapped = i_paddr == `HOF_ADDR || i_paddr == `HOF_WDATA || i_paddr == `HOF_CMD
		|| i_paddr == `HOF_STATUS || i_paddr == `HOF_PIN;
	logic [31:0] status_word;
	assign status_word = {last_rd_reg, 13'h0000, !bus.power_event_out ? 1'b0 : 1'b1,
		!bus.host_irq_n, busy};
	logic [31:0] rd_val;
	assign rd_val = (i_paddr == `HOF_ADDR) ? {24'h00_0000, addr_reg} :
		(i_paddr == `HOF_WDATA) ? {16'h0000, wdata_reg} :
		(i_paddr == `HOF_STATUS) ? status_word :
		(i_paddr == `HOF_PIN) ? {31'h0000_0000, pd_n_reg} : 32'h0000_0000;
	logic start;
	assign start = done && i_pwrite && i_paddr == `HOF_CMD && !busy;

	// ****************************************
	// Device bus sequencer
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			addr_reg <= 8'h00;
			wdata_reg <= 16'h0000;
			last_rd_reg <= 16'h0000;
			pd_n_reg <= 1'b1;
			cs_reg <= 1'b0;
			wr_reg <= 1'b0;
			hs_reg <= HS_IDLE;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else if (i_ce) begin
			pready_reg <= access && !pready_reg;
			if (access && !pready_reg) begin
				prdata_reg <= rd_val;
				pslverr_reg <= !mapped;
			end
			if (done && i_pwrite && i_paddr == `HOF_ADDR) addr_reg <= i_pwdata[7:0];
			if (done && i_pwrite && i_paddr == `HOF_WDATA) wdata_reg <= i_pwdata[15:0];
			if (done && i_pwrite && i_paddr == `HOF_PIN) pd_n_reg <= i_pwdata[0];
			unique case (hs_reg)
				HS_IDLE: begin
					if (start) begin
						cs_reg <= 1'b1;
						wr_reg <= i_pwdata[0];
						hs_reg <= HS_REQ;
					end
				end
				HS_REQ: begin
					if (bus.ack) begin
						cs_reg <= 1'b0;
						if (!wr_reg) last_rd_reg <= bus.rdata;
						hs_reg <= HS_GAP;
					end
				end
				HS_GAP: hs_reg <= HS_IDLE;
			endcase
		end
	end
	assign o_prdata = prdata_reg;
	assign o_pready = pready_reg;
	assign o_pslverr = pslverr_reg;
	assign bus.cs = cs_reg;
	assign bus.wr = wr_reg;
	assign bus.addr = addr_reg;
	assign bus.wdata = wdata_reg;
	assign bus.chip_power_down_n = pd_n_reg;
endmodule
`default_nettype wire

// *** power_link_assertions.sv ***
// Concurrent checks on the link between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module power_link_assertions (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic cs,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic ack,
	input wire logic host_irq_n,
	input wire logic power_event_out,
	input wire logic chip_power_down_n
);
	logic [3:0] ack_age_reg;
	logic [3:0] ack_age_next;
	// Cycles since the last answer, saturating
	assign ack_age_next = ack ? 4'h0 : ((ack_age_reg == 4'hf) ? 4'hf : ack_age_reg + 4'h1);
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			ack_age_reg <= 4'hf;
		end else begin
			ack_age_reg <= ack_age_next;
		end
	end
	default clocking dclk @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	// ************************************************************
	// Link assertions
	// ************************************************************
	ack_pulse_a: assert property (ack |=> !ack)
		else $error("answer held longer than one cycle");
	ack_answer_a: assert property (cs && !ack && chip_power_down_n |=> ack)
		else $error("request not answered in the next cycle");
	ack_cause_a: assert property (ack |-> $past(cs) && !$past(ack))
		else $error("answer without a request");
	cs_release_a: assert property (ack |-> ##[1:2] !cs)
		else $error("request not released after answer");
	req_hold_a: assert property (cs && !ack |=>
		$stable(addr) && $stable(wr) && $stable(wdata))
		else $error("request changed before answer");
	pdn_reset_a: assert property (!chip_power_down_n |=>
		host_irq_n && !power_event_out && !ack && rdata == 16'h0000)
		else $error("power-down pin did not reset outputs");
	rdata_hold_a: assert property (!ack && chip_power_down_n && $past(chip_power_down_n)
		|-> $stable(rdata))
		else $error("read data changed without an answer");
	flag_clear_a: assert property ($rose(host_irq_n) || $fell(power_event_out)
		|-> ack_age_reg <= 4'h4 || !$past(chip_power_down_n))
		else $error("event output released without a host access");
endmodule
`default_nettype wire

// *** power_mode_wake_control.sv ***
// Power mode, sleep/wake timing and wake event control of the device end
`timescale 1ns/1ps
`default_nettype none
`include "pmw_consts.svh"
// Summary of operation
// - Mode field selects normal, energy, soft-down, saving
// - Reset leaves mode field at normal
// - Host writes mode field from normal mode
// - Low power state keeps only energy detector
// - No energy past go-sleep time enters low
// - Energy past wake time with auto-wake returns
// - Auto-wake plus wake-to-normal restores normal mode
// - Energy event raises power event if enabled
// - Energy event raises host interrupt if enabled
// - Wake register read wakes from low state
// - Cable traffic off in low and soft-down states, and in saving without energy
// - Soft down: all off, registers held
// - Wake register read leaves soft down
// - Saving needs autoneg, no cable, bit ten
// - Saving keeps clocks, MAC, TX; RX repowers
// - Host leaves saving by rewriting mode, bit
// - Power-down pin low resets whole chip
// - Energy and linkup set status bits two, three
// - Remote wake and wake frame set four, five
// - Events reported by interrupt, power event, both
module power_mode_wake_control
	import pmw_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_ce,
	pmw_if.dev bus,
	input wire logic i_energy,
	input wire logic i_link_up,
	input wire logic i_autoneg_en,
	input wire logic i_cable_present,
	input wire logic i_remote_wake,
	input wire logic i_wake_frame,
	output logic o_pll_clk_en,
	output logic o_mac_en,
	output logic o_host_if_en,
	output logic o_phy_tx_en,
	output logic o_phy_rx_en,
	output logic o_rx_unused_off,
	output logic o_energy_det_en,
	output logic o_traffic_en,
	output logic [2:0] o_power_state
);
	// ****************************************
	// Reset and pin synchronisers
	// ****************************************
	logic rst;
	assign rst = !i_rstn || !bus.chip_power_down_n;
	localparam int NPIN = 6;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_f;
	assign pin_raw = {i_wake_frame, i_remote_wake, i_cable_present, i_autoneg_en,
		i_link_up, i_energy};
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic f_reg;
			always_ff @(posedge i_mclk) begin
				if (rst) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					f_reg <= 1'b0;
				end else if (i_ce) begin
					s1_reg <= pin_raw[gi];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						f_reg <= s3_reg;
					end
				end
			end
			assign pin_f[gi] = f_reg;
		end
	endgenerate
	logic energy;
	logic link_up;
	logic autoneg;
	logic cable;
	logic remote;
	logic wframe;
	assign energy = pin_f[0];
	assign link_up = pin_f[1];
	assign autoneg = pin_f[2];
	assign cable = pin_f[3];
	assign remote = pin_f[4];
	assign wframe = pin_f[5];

	// ****************************************
	// Registers and bus decode
	// ****************************************
	logic [15:0] grr_reg;
	logic [15:0] ier_reg;
	logic [15:0] swt_reg;
	logic [15:0] pec_reg;
	logic [15:0] pec_next;
	logic [15:0] plc_reg;
	logic [3:0] isr_reg;
	logic [15:0] rdata_reg;
	logic ack_reg;
	logic asleep_reg;
	logic asleep_next;
	logic hit_done_reg;
	power_state_t state_reg;
	power_state_t state_next;
	logic [1:0] mode;
	assign mode = pec_reg[1:0];
	logic host_if_on;
	assign host_if_on = !(mode == `MODE_SOFT_DOWN)
		&& !(mode == `MODE_ENERGY && asleep_reg);
	logic req;
	assign req = bus.cs && !ack_reg;
	logic grr_rd;
	assign grr_rd = req && !bus.wr && bus.addr == `OFS_GLOBAL_RESET_WAKE;
	logic acc_ok;
	assign acc_ok = req && host_if_on;
	logic wr_ok;
	assign wr_ok = acc_ok && bus.wr;
	logic wr_grr, wr_ier, wr_isr, wr_swt, wr_pec, wr_plc;
	assign wr_grr = wr_ok && bus.addr == `OFS_GLOBAL_RESET_WAKE;
	assign wr_ier = wr_ok && bus.addr == `OFS_INTERRUPT_ENABLE;
	assign wr_isr = wr_ok && bus.addr == `OFS_INTERRUPT_STATUS;
	assign wr_swt = wr_ok && bus.addr == `OFS_SLEEP_WAKE_TIME;
	assign wr_pec = wr_ok && bus.addr == `OFS_POWER_EVENT_CONTROL;
	assign wr_plc = wr_ok && bus.addr == `OFS_PORT_LINK_CONTROL;
	logic [15:0] isr_word;
	assign isr_word = {10'h000, isr_reg, 2'h0};
	logic [15:0] rd_val;
	assign rd_val = (bus.addr == `OFS_GLOBAL_RESET_WAKE) ? grr_reg :
		(bus.addr == `OFS_INTERRUPT_ENABLE) ? ier_reg :
		(bus.addr == `OFS_INTERRUPT_STATUS) ? isr_word :
		(bus.addr == `OFS_SLEEP_WAKE_TIME) ? swt_reg :
		(bus.addr == `OFS_POWER_EVENT_CONTROL) ? pec_reg :
		(bus.addr == `OFS_PORT_LINK_CONTROL) ? plc_reg : 16'h0000;

	// ****************************************
	// Tick base and energy timer
	// ****************************************
	logic [15:0] tick_cnt_reg;
	logic tick;
	assign tick = tick_cnt_reg == 16'(TICK_CYCLES - 1);
	logic energy_prev_reg;
	logic [8:0] en_cnt_reg;
	logic en_change;
	assign en_change = energy != energy_prev_reg;
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			tick_cnt_reg <= 16'h0000;
			energy_prev_reg <= 1'b0;
			en_cnt_reg <= 9'h000;
		end else if (i_ce) begin
			tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
			energy_prev_reg <= energy;
			if (en_change) begin
				en_cnt_reg <= 9'h000;
			end else if (tick && en_cnt_reg != 9'h1ff) begin
				en_cnt_reg <= en_cnt_reg + 9'h001;
			end
		end
	end
	logic [8:0] sleep_time;
	logic [8:0] wake_time;
	assign sleep_time = {1'b0, swt_reg[`SWT_SLEEP_LSB +: 8]};
	assign wake_time = {1'b0, swt_reg[`SWT_WAKE_LSB +: 8]};
	logic go_sleep;
	assign go_sleep = mode == `MODE_ENERGY && !asleep_reg && !energy
		&& !en_change && en_cnt_reg > sleep_time;
	logic ed_hit;
	assign ed_hit = mode == `MODE_ENERGY && asleep_reg && energy && !en_change
		&& en_cnt_reg > wake_time && !hit_done_reg;
	logic auto_wake;
	logic to_normal;
	assign auto_wake = pec_reg[`PEC_AUTO_WAKE];
	assign to_normal = pec_reg[`PEC_WAKE_TO_NORMAL];

	// ****************************************
	// Mode and sleep state
	// ****************************************
	always_comb begin
		pec_next = pec_reg;
		asleep_next = asleep_reg;
		if (wr_pec) begin
			pec_next = bus.wdata;
		end
		if (go_sleep) begin
			asleep_next = 1'b1;
		end
		if (ed_hit && auto_wake) begin
			asleep_next = 1'b0;
			if (to_normal) begin
				pec_next[1:0] = `MODE_NORMAL;
			end
		end
		if (grr_rd) begin
			asleep_next = 1'b0;
			if (mode == `MODE_SOFT_DOWN) begin
				pec_next[1:0] = `MODE_NORMAL;
			end
		end
		if (pec_next[1:0] != `MODE_ENERGY) begin
			asleep_next = 1'b0;
		end
	end
	logic save_ok;
	assign save_ok = plc_reg[`PLC_SAVE_EN] && autoneg && !cable;
	always_comb begin
		unique case (pec_next[1:0])
			`MODE_NORMAL: state_next = PS_NORMAL;
			`MODE_ENERGY: state_next = asleep_next ? PS_ED_LOW : PS_ED_AWAKE;
			`MODE_SOFT_DOWN: state_next = PS_SOFT_DOWN;
			`MODE_SAVING: state_next = save_ok ? PS_SAVE : PS_SAVE_WAIT;
		endcase
	end

	// ****************************************
	// Wake events and status
	// ****************************************
	logic link_prev_reg, remote_prev_reg, wframe_prev_reg;
	logic [3:0] ev_set;
	assign ev_set = {wframe && !wframe_prev_reg, remote && !remote_prev_reg,
		link_up && !link_prev_reg, ed_hit};
	logic [3:0] ev_clr;
	assign ev_clr = wr_isr ? bus.wdata[`IRQ_EV_LSB +: 4] : 4'h0;
	logic [3:0] irq_en;
	logic [3:0] pme_en;
	assign irq_en = ier_reg[`IRQ_EV_LSB +: 4];
	assign pme_en = pec_reg[`PEC_PME_EN_LSB +: 4];
	logic irq_n_reg;
	logic pme_reg;

	always_ff @(posedge i_mclk) begin
		if (rst) begin
			grr_reg <= `RST_GLOBAL_RESET_WAKE;
			ier_reg <= `RST_INTERRUPT_ENABLE;
			swt_reg <= `RST_SLEEP_WAKE_TIME;
			pec_reg <= `RST_POWER_EVENT_CONTROL;
			plc_reg <= `RST_PORT_LINK_CONTROL;
			isr_reg <= 4'h0;
			rdata_reg <= 16'h0000;
			ack_reg <= 1'b0;
			asleep_reg <= 1'b0;
			hit_done_reg <= 1'b0;
			state_reg <= PS_NORMAL;
			link_prev_reg <= 1'b0;
			remote_prev_reg <= 1'b0;
			wframe_prev_reg <= 1'b0;
			irq_n_reg <= 1'b1;
			pme_reg <= 1'b0;
		end else if (i_ce) begin
			if (wr_grr) grr_reg <= bus.wdata;
			if (wr_ier) ier_reg <= bus.wdata;
			if (wr_swt) swt_reg <= bus.wdata;
			if (wr_plc) plc_reg <= bus.wdata;
			pec_reg <= pec_next;
			isr_reg <= (isr_reg & ~ev_clr) | ev_set;
			ack_reg <= req;
			if (req) begin
				rdata_reg <= (acc_ok && !bus.wr) ? rd_val : 16'h0000;
			end
			asleep_reg <= asleep_next;
			hit_done_reg <= asleep_next && (hit_done_reg || ed_hit);
			state_reg <= state_next;
			link_prev_reg <= link_up;
			remote_prev_reg <= remote;
			wframe_prev_reg <= wframe;
			irq_n_reg <= !(|(isr_reg & irq_en));
			pme_reg <= |(isr_reg & pme_en);
		end
	end

	// ****************************************
	// Block enables
	// ****************************************
	logic [7:0] en_vec;
	logic [7:0] en_reg;
	always_comb begin
		unique case (state_reg)
			PS_ED_LOW: en_vec = 8'h40;
			PS_SOFT_DOWN: en_vec = 8'h00;
			PS_SAVE: en_vec = {energy, 1'b0, !energy, energy, 4'hf};
			default: en_vec = 8'h9f;
		endcase
	end
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			en_reg <= 8'h00;
		end else if (i_ce) begin
			en_reg <= en_vec;
		end
	end
	assign o_pll_clk_en = en_reg[0];
	assign o_mac_en = en_reg[1];
	assign o_host_if_en = en_reg[2];
	assign o_phy_tx_en = en_reg[3];
	assign o_phy_rx_en = en_reg[4];
	assign o_rx_unused_off = en_reg[5];
	assign o_energy_det_en = en_reg[6];
	assign o_traffic_en = en_reg[7];
	assign o_power_state = state_reg;
	assign bus.rdata = rdata_reg;
	assign bus.ack = ack_reg;
	assign bus.host_irq_n = irq_n_reg;
	assign bus.power_event_out = pme_reg;
endmodule
`default_nettype wire

// *** tb_power_mode_wake_control.sv ***
// Testbench for the host end and the device end joined by the link
`timescale 1ns/1ps
`default_nettype none
`include "pmw_consts.svh"
module tb_power_mode_wake_control;
	import pmw_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] pa = 8'h00;
	logic [31:0] pwd = 32'h0000_0000;
	logic nrg = 1'b0;
	logic lnk = 1'b0;
	logic cab = 1'b1;
	logic atn = 1'b1;
	logic rwk = 1'b0;
	logic wfr = 1'b0;
	logic [31:0] rd;
	logic er;
	logic [15:0] q;
	logic [15:0] cfg [3] = '{16'h0101, 16'h0181, 16'h01c1};
	wire logic [31:0] prd;
	wire logic prdy;
	wire logic perr;
	wire logic [7:0] en;
	wire logic [2:0] st;
	wire logic [2:0] obs;
	int failures = 0;
	int num_checks = 0;
	pmw_if pif();
	assign obs = {pif.host_irq_n, pif.power_event_out, en[3]};
	power_host_end u_power_host_end(.i_mclk(clk), .i_rstn(rstn), .i_ce(1'b1), .bus(pif.host),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
		.o_prdata(prd), .o_pready(prdy), .o_pslverr(perr));
	power_mode_wake_control #(.TICK_CYCLES(4)) u_power_mode_wake_control(.i_mclk(clk),
		.i_rstn(rstn), .i_ce(1'b1), .bus(pif.dev), .i_energy(nrg), .i_link_up(lnk),
		.i_autoneg_en(atn), .i_cable_present(cab), .i_remote_wake(rwk), .i_wake_frame(wfr),
		.o_pll_clk_en(en[7]), .o_mac_en(en[6]), .o_host_if_en(en[5]), .o_phy_tx_en(en[4]),
		.o_phy_rx_en(en[3]), .o_rx_unused_off(en[2]), .o_energy_det_en(en[1]),
		.o_traffic_en(en[0]), .o_power_state(st));
	power_link_assertions u_power_link_assertions(.i_mclk(clk), .i_rstn(rstn), .cs(pif.cs),
		.wr(pif.wr), .addr(pif.addr), .wdata(pif.wdata), .rdata(pif.rdata), .ack(pif.ack),
		.host_irq_n(pif.host_irq_n), .power_event_out(pif.power_event_out),
		.chip_power_down_n(pif.chip_power_down_n));
	initial begin
		forever #20 clk = ~clk;
	end
	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic timeout();
		failures++;
		$display("mismatch at %0t: wait ran out", $time);
		final_report();
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 50);
		if (n >= 50) timeout();
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic dev(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n = 0;
		apb(1'b1, `HOF_ADDR, 32'(a));
		apb(1'b1, `HOF_WDATA, 32'(d));
		apb(1'b1, `HOF_CMD, 32'(w));
		do begin
			apb(1'b0, `HOF_STATUS, 32'h0000_0000);
			n++;
		end while (rd[0] !== 1'b0 && n < 20);
		if (n >= 20) timeout();
		q = rd[31:16];
	endtask
	task automatic wait_st(input logic [2:0] e);
		int n = 0;
		while (st !== e && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (n >= 300) timeout();
		chk(16'(st), 16'(e));
	endtask
	task automatic wait_obs(input int i, input logic e);
		int n = 0;
		while (obs[i] !== e && n < 300) begin
			@(posedge clk);
			n++;
		end
		if (n >= 300) timeout();
		chk(16'(obs[i]), 16'(e));
	endtask
	task automatic chk_en(input logic [7:0] m, input logic [7:0] e);
		repeat (2) @(posedge clk);
		chk(16'(en & m), 16'(e));
	endtask
	initial begin
		#2000000;
		timeout();
	end
	// ************************************************************
	// Sequence
	// ************************************************************
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		wait_st(PS_NORMAL);
		chk_en(8'hff, 8'hf9);
		dev(1'b0, `OFS_POWER_EVENT_CONTROL, 16'h0000);
		chk(q, `RST_POWER_EVENT_CONTROL);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk(16'(er), 16'h0001);
		dev(1'b1, `OFS_POWER_EVENT_CONTROL, 16'h0c00);
		dev(1'b1, `OFS_INTERRUPT_ENABLE, 16'h0028);
		for (int k = 3; k < 6; k++) begin
			lnk <= (k == 3);
			rwk <= (k == 4);
			wfr <= (k == 5);
			repeat (8) @(posedge clk);
			dev(1'b0, `OFS_INTERRUPT_STATUS, 16'h0000);
			chk(q, 16'(1 << k));
			chk(16'({pif.host_irq_n, pif.power_event_out}), 16'({k == 4, k != 3}));
			apb(1'b0, `HOF_STATUS, 32'h0000_0000);
			chk(16'(rd[2:1]), 16'({k != 3, k != 4}));
			dev(1'b1, `OFS_INTERRUPT_STATUS, 16'h003c);
		end
		wfr <= 1'b0;
		dev(1'b1, `OFS_INTERRUPT_ENABLE, 16'h0004);
		dev(1'b1, `OFS_SLEEP_WAKE_TIME, 16'h0302);
		for (int c = 0; c < 3; c++) begin
			nrg <= 1'b0;
			dev(1'b1, `OFS_POWER_EVENT_CONTROL, cfg[c]);
			wait_st(PS_ED_LOW);
			chk_en(8'hff, 8'h02);
			nrg <= 1'b1;
			wait_obs(2, 1'b0);
			chk(16'(pif.power_event_out), 16'h0001);
			if (c == 0) begin
				chk(16'(st), 16'(PS_ED_LOW));
				dev(1'b0, `OFS_GLOBAL_RESET_WAKE, 16'h0000);
			end
			wait_st((c == 2) ? PS_NORMAL : PS_ED_AWAKE);
			dev(1'b0, `OFS_POWER_EVENT_CONTROL, 16'h0000);
			chk(q & 16'h0003, (c == 2) ? 16'(`MODE_NORMAL) : 16'(`MODE_ENERGY));
			dev(1'b1, `OFS_INTERRUPT_STATUS, 16'h003c);
			wait_obs(2, 1'b1);
		end
		dev(1'b1, `OFS_INTERRUPT_ENABLE, 16'h003c);
		dev(1'b1, `OFS_POWER_EVENT_CONTROL, 16'h0002);
		wait_st(PS_SOFT_DOWN);
		chk_en(8'hff, 8'h00);
		dev(1'b1, `OFS_INTERRUPT_ENABLE, 16'h0000);
		dev(1'b0, `OFS_INTERRUPT_ENABLE, 16'h0000);
		chk(q, 16'h0000);
		dev(1'b0, `OFS_GLOBAL_RESET_WAKE, 16'h0000);
		wait_st(PS_NORMAL);
		dev(1'b0, `OFS_INTERRUPT_ENABLE, 16'h0000);
		chk(q, 16'h003c);
		nrg <= 1'b0;
		dev(1'b1, `OFS_PORT_LINK_CONTROL, 16'h0400);
		dev(1'b1, `OFS_POWER_EVENT_CONTROL, 16'h0003);
		wait_st(PS_SAVE_WAIT);
		atn <= 1'b0;
		cab <= 1'b0;
		repeat (8) @(posedge clk);
		chk(16'(st), 16'(PS_SAVE_WAIT));
		atn <= 1'b1;
		wait_st(PS_SAVE);
		chk_en(8'hfd, 8'hf4);
		nrg <= 1'b1;
		wait_obs(0, 1'b1);
		dev(1'b1, `OFS_PORT_LINK_CONTROL, 16'h0000);
		dev(1'b1, `OFS_POWER_EVENT_CONTROL, 16'h0000);
		wait_st(PS_NORMAL);
		apb(1'b1, `HOF_PIN, 32'h0000_0000);
		repeat (3) @(posedge clk);
		chk(16'({pif.ack, pif.host_irq_n, pif.power_event_out}), 16'h0002);
		apb(1'b1, `HOF_PIN, 32'h0000_0001);
		dev(1'b0, `OFS_INTERRUPT_ENABLE, 16'h0000);
		chk(q, `RST_INTERRUPT_ENABLE);
		dev(1'b0, `OFS_SLEEP_WAKE_TIME, 16'h0000);
		chk(q, `RST_SLEEP_WAKE_TIME);
		final_report();
	end
endmodule
`default_nettype wire
